//--- rtl/tlpwm_top.sv
// Triple pwm generator with shared counter, output routing, combination and comparator gating.
//
// Design decisions made here: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "tlpwm_regs.svh"

module tlpwm_top
  import tlpwm_pkg::*;
(
  // Clock and reset.
  input  wire logic        i_core_clk,
  input  wire logic        i_nrst,
  // Avalon-MM slave.
  input  wire logic [7:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  output logic [31:0]      o_avs_readdata,
  output logic             o_avs_waitrequest,
  // Asynchronous inputs from outside this clock domain.
  input  wire logic        i_fast_osc,
  input  wire logic        i_comparator,
  // Pin outputs; enables are low while the pin is driven.
  output logic             o_pin_a3,
  output logic             o_pin_a3_en_n,
  output logic             o_pin_a4,
  output logic             o_pin_a4_en_n,
  output logic             o_pin_a0,
  output logic             o_pin_a0_en_n,
  output logic             o_pin_a7,
  output logic             o_pin_a7_en_n
);

  // Register file.
  logic [7:0]  pwm_clock_control_q;
  logic [7:0]  counter_bound_high_q;
  logic [7:0]  counter_bound_low_q;
  logic [7:0]  duty_bound_high_q [3];
  logic [7:0]  duty_bound_low_q [3];
  logic [7:0]  channel_output_control_q [3];
  logic [2:0]  comparator_gate_select_q;
  logic        ack_q;
  logic [31:0] readdata_q;
  logic [31:0] read_mux;
  // Synchronisers and time base.
  logic        osc_s1_q, osc_s2_q, osc_s3_q;
  logic        comp_s1_q, comp_s2_q;
  logic        tick;
  logic [6:0]  pre_cnt_q;
  logic [6:0]  pre_last;
  logic [6:0]  half_lim;
  logic        step;
  logic        first_half;
  logic [9:0]  count_q;
  logic [9:0]  counter_bound_bits;
  logic        run;
  // Waveforms.
  logic [2:0]  wave;
  logic [2:0]  out_wave;
  logic        pin_a3_q, pin_a4_q, pin_a0_q, pin_a7_q;
  logic        pin_a3_en_n_q, pin_a4_en_n_q, pin_a0_en_n_q, pin_a7_en_n_q;

  // The answer always comes one cycle after the request is first seen.
  assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !ack_q;
  assign o_avs_readdata    = readdata_q;

  // Read decode; unmapped offsets read zero.
  always_comb
  begin
    read_mux = 32'h00000000;
    case (i_avs_address)
      `TLPWM_OFS_CLOCK_CONTROL:    read_mux[7:0] = pwm_clock_control_q;
      `TLPWM_OFS_BOUND_HIGH:       read_mux[7:0] = counter_bound_high_q;
      `TLPWM_OFS_BOUND_LOW:        read_mux[7:0] = counter_bound_low_q;
      `TLPWM_OFS_CH0_DUTY_HIGH:    read_mux[7:0] = duty_bound_high_q[0];
      `TLPWM_OFS_CH0_DUTY_LOW:     read_mux[7:0] = duty_bound_low_q[0];
      `TLPWM_OFS_CH0_OUT_CONTROL:  read_mux[7:0] = channel_output_control_q[0];
      `TLPWM_OFS_CH1_DUTY_HIGH:    read_mux[7:0] = duty_bound_high_q[1];
      `TLPWM_OFS_CH1_DUTY_LOW:     read_mux[7:0] = duty_bound_low_q[1];
      `TLPWM_OFS_CH1_OUT_CONTROL:  read_mux[7:0] = channel_output_control_q[1];
      `TLPWM_OFS_CH2_DUTY_HIGH:    read_mux[7:0] = duty_bound_high_q[2];
      `TLPWM_OFS_CH2_DUTY_LOW:     read_mux[7:0] = duty_bound_low_q[2];
      `TLPWM_OFS_CH2_OUT_CONTROL:  read_mux[7:0] = channel_output_control_q[2];
      `TLPWM_OFS_COMP_GATE_SELECT: read_mux[2:0] = comparator_gate_select_q;
      `TLPWM_OFS_COUNTER_STATUS:   read_mux      = {wave, 19'h00000, count_q};
      default:                     read_mux      = 32'h00000000;
    endcase
  end

  // Handshake and read data capture.
  always_ff @(posedge i_core_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      ack_q      <= 1'b0;
      readdata_q <= 32'h00000000;
    end
    else
    begin
      ack_q <= o_avs_waitrequest;
      if (o_avs_waitrequest && i_avs_read)
        readdata_q <= read_mux;
    end
  end

  // Register writes take effect at the edge where waitrequest is low.
  always_ff @(posedge i_core_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      pwm_clock_control_q      <= `TLPWM_REG_RESET;
      counter_bound_high_q     <= `TLPWM_REG_RESET;
      counter_bound_low_q      <= `TLPWM_REG_RESET;
      comparator_gate_select_q <= 3'h0;
      for (int i = 0; i < 3; i++)
      begin
        duty_bound_high_q[i]        <= `TLPWM_REG_RESET;
        duty_bound_low_q[i]         <= `TLPWM_REG_RESET;
        channel_output_control_q[i] <= `TLPWM_REG_RESET;
      end
    end
    else if (i_avs_write && ack_q)
    begin
      case (i_avs_address)
        `TLPWM_OFS_CLOCK_CONTROL:    pwm_clock_control_q         <= i_avs_writedata[7:0];
        `TLPWM_OFS_BOUND_HIGH:       counter_bound_high_q        <= i_avs_writedata[7:0];
        `TLPWM_OFS_BOUND_LOW:        counter_bound_low_q         <= i_avs_writedata[7:0];
        `TLPWM_OFS_CH0_DUTY_HIGH:    duty_bound_high_q[0]        <= i_avs_writedata[7:0];
        `TLPWM_OFS_CH0_DUTY_LOW:     duty_bound_low_q[0]         <= i_avs_writedata[7:0];
        `TLPWM_OFS_CH0_OUT_CONTROL:  channel_output_control_q[0] <= i_avs_writedata[7:0];
        `TLPWM_OFS_CH1_DUTY_HIGH:    duty_bound_high_q[1]        <= i_avs_writedata[7:0];
        `TLPWM_OFS_CH1_DUTY_LOW:     duty_bound_low_q[1]         <= i_avs_writedata[7:0];
        `TLPWM_OFS_CH1_OUT_CONTROL:  channel_output_control_q[1] <= i_avs_writedata[7:0];
        `TLPWM_OFS_CH2_DUTY_HIGH:    duty_bound_high_q[2]        <= i_avs_writedata[7:0];
        `TLPWM_OFS_CH2_DUTY_LOW:     duty_bound_low_q[2]         <= i_avs_writedata[7:0];
        `TLPWM_OFS_CH2_OUT_CONTROL:  channel_output_control_q[2] <= i_avs_writedata[7:0];
        `TLPWM_OFS_COMP_GATE_SELECT: comparator_gate_select_q    <= i_avs_writedata[2:0];
        default:                     ;
      endcase
    end
  end

  // Two-stage synchronisers; the third oscillator stage only feeds edge detection.
  always_ff @(posedge i_core_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      osc_s1_q  <= 1'b0;
      osc_s2_q  <= 1'b0;
      osc_s3_q  <= 1'b0;
      comp_s1_q <= 1'b0;
      comp_s2_q <= 1'b0;
    end
    else
    begin
      osc_s1_q  <= i_fast_osc;
      osc_s2_q  <= osc_s1_q;
      osc_s3_q  <= osc_s2_q;
      comp_s1_q <= i_comparator;
      comp_s2_q <= comp_s1_q;
    end
  end

  // Clock source and prescale decode shared by all three channels.
  // The fast oscillator is sampled, so it must run below half the core clock.
  always_comb
  begin
    run      = pwm_clock_control_q[`TLPWM_CLK_ENABLE_BIT];
    tick     = (pwm_clock_control_q[`TLPWM_CLK_SOURCE_BIT] == TLPWM_SRC_FAST) ?
               (osc_s2_q && !osc_s3_q) : 1'b1;
    pre_last = 7'((8'h01 << pwm_clock_control_q[`TLPWM_CLK_PRESCALE_MSB:`TLPWM_CLK_PRESCALE_LSB]) - 8'h01);
    half_lim = 7'((8'h01 << pwm_clock_control_q[`TLPWM_CLK_PRESCALE_MSB:`TLPWM_CLK_PRESCALE_LSB]) >> 1);
    step     = run && tick && (pre_cnt_q == pre_last);
    first_half = pre_cnt_q < half_lim;
    counter_bound_bits = tlpwm_bits10(counter_bound_high_q, counter_bound_low_q);
  end

  // Prescaler counts source ticks and restarts on each counter step.
  always_ff @(posedge i_core_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      pre_cnt_q <= 7'h00;
    else if (!run)
      pre_cnt_q <= 7'h00;
    else if (tick)
      pre_cnt_q <= (pre_cnt_q >= pre_last) ? 7'h00 : pre_cnt_q + 7'h01;
  end

  // Shared up-counter; a bound lowered below the count wraps it at the next step.
  always_ff @(posedge i_core_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      count_q <= 10'h000;
    else if (!run)
      count_q <= 10'h000;
    else if (step)
      count_q <= (count_q >= counter_bound_bits) ? 10'h000 : count_q + 10'h001;
  end

  // Three channels compare against the same count so their cycles start together.
  for (genvar g = 0; g < 3; g++)
  begin : g_chan
    tlpwm_chan #(.W(10)) u_chan
    (
      .i_core_clk   (i_core_clk),
      .i_nrst       (i_nrst),
      .i_count      (count_q),
      .i_first_half (first_half),
      .i_duty_high  (duty_bound_high_q[g]),
      .i_duty_low   (duty_bound_low_q[g]),
      .o_wave_q     (wave[g])
    );
  end

  // Combination, inversion and gating; a gated channel is held low, not frozen.
  always_comb
  begin
    case (tlpwm_mix_t'({channel_output_control_q[0][`TLPWM_OUT_OR_BIT],
                        channel_output_control_q[0][`TLPWM_OUT_XOR_BIT]}))
      TLPWM_MIX_XOR:  out_wave[0] = wave[0] ^ wave[1];
      TLPWM_MIX_OR:   out_wave[0] = wave[0] | wave[1];
      TLPWM_MIX_BOTH: out_wave[0] = (wave[0] ^ wave[1]) | wave[1];
      default:        out_wave[0] = wave[0];
    endcase
    out_wave[1] = wave[1];
    out_wave[2] = wave[2];
    for (int i = 0; i < 3; i++)
    begin
      out_wave[i] = out_wave[i] ^ channel_output_control_q[i][`TLPWM_OUT_INVERT_BIT];
      if (comparator_gate_select_q[i] && comp_s2_q)
        out_wave[i] = 1'b0;
    end
  end

  // Registered pin drive and routing.
  always_ff @(posedge i_core_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      pin_a3_q      <= 1'b0;
      pin_a4_q      <= 1'b0;
      pin_a0_q      <= 1'b0;
      pin_a7_q      <= 1'b0;
      pin_a3_en_n_q <= 1'b1;
      pin_a4_en_n_q <= 1'b1;
      pin_a0_en_n_q <= 1'b1;
      pin_a7_en_n_q <= 1'b1;
    end
    else
    begin
      pin_a3_q      <= out_wave[0];
      pin_a4_q      <= out_wave[1];
      pin_a0_q      <= out_wave[2];
      pin_a7_q      <= out_wave[2];
      pin_a3_en_n_q <= !channel_output_control_q[0][`TLPWM_OUT_PIN_FIRST_BIT];
      pin_a4_en_n_q <= !channel_output_control_q[1][`TLPWM_OUT_PIN_FIRST_BIT];
      pin_a0_en_n_q <= !channel_output_control_q[2][`TLPWM_OUT_PIN_FIRST_BIT];
      pin_a7_en_n_q <= !channel_output_control_q[2][`TLPWM_OUT_PIN_SECOND_BIT];
    end
  end

  assign o_pin_a3      = pin_a3_q;
  assign o_pin_a4      = pin_a4_q;
  assign o_pin_a0      = pin_a0_q;
  assign o_pin_a7      = pin_a7_q;
  assign o_pin_a3_en_n = pin_a3_en_n_q;
  assign o_pin_a4_en_n = pin_a4_en_n_q;
  assign o_pin_a0_en_n = pin_a0_en_n_q;
  assign o_pin_a7_en_n = pin_a7_en_n_q;

  // Bus request waits exactly one cycle before it is answered.
  sequence s_new_req;
    (i_avs_read || i_avs_write) && !ack_q;
  endsequence

  AST_BUS_WAIT: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    s_new_req |-> o_avs_waitrequest ##1 !o_avs_waitrequest)
    else $error("Bus answer not given one cycle after request.");

  AST_SYSCLK_TICK: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (pwm_clock_control_q[`TLPWM_CLK_SOURCE_BIT] == TLPWM_SRC_SYSTEM) |-> tick)
    else $error("System clock source does not tick every cycle.");

  AST_COUNT_HOLD: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    run && !step && $past(run) |=> $stable(count_q))
    else $error("Counter moved without a prescaled step.");

  AST_COUNT_UP: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    step && (count_q < counter_bound_bits) |=> count_q == $past(count_q) + 10'h001)
    else $error("Counter did not advance by one.");

  AST_WRAP: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    step && (count_q == counter_bound_bits) |=> count_q == 10'h000)
    else $error("Counter did not wrap after the bound.");

  AST_DISABLED: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    !run |=> (count_q == 10'h000) && (pre_cnt_q == 7'h00))
    else $error("Counter runs while disabled.");

  AST_PRESCALE_RANGE: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    run && tick |=> pre_cnt_q <= $past(pre_last))
    else $error("Prescaler beyond the selected division.");

  sequence s_gated;
    comparator_gate_select_q[0] && comp_s2_q;
  endsequence

  AST_GATE_STOP: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    s_gated |=> !o_pin_a3)
    else $error("Gated channel zero still drives high.");

  AST_XOR_MIX: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    channel_output_control_q[0][`TLPWM_OUT_XOR_BIT] && !channel_output_control_q[0][`TLPWM_OUT_OR_BIT] &&
    !comparator_gate_select_q[0] |=>
    o_pin_a3 == ($past(wave[0] ^ wave[1]) ^ $past(channel_output_control_q[0][`TLPWM_OUT_INVERT_BIT])))
    else $error("Channel zero xor combination wrong.");

  AST_INVERT_CH2: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    !comparator_gate_select_q[2] |=> o_pin_a0 == ($past(wave[2]) ^ $past(channel_output_control_q[2][7])))
    else $error("Channel two inversion wrong.");

  AST_ROUTE_OFF: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    !channel_output_control_q[1][`TLPWM_OUT_PIN_FIRST_BIT] |=> o_pin_a4_en_n)
    else $error("Disabled channel one still drives its pin.");

endmodule // tlpwm_top

//--- include/tlpwm_regs.svh
// Register offsets, field positions, reset values and timing figures of the triple pwm generator.
`ifndef TLPWM_REGS_SVH
`define TLPWM_REGS_SVH

// Byte offsets of the word-aligned registers.
`define TLPWM_OFS_CLOCK_CONTROL     8'h00
`define TLPWM_OFS_BOUND_HIGH        8'h04
`define TLPWM_OFS_BOUND_LOW         8'h08
`define TLPWM_OFS_CH0_DUTY_HIGH     8'h0C
`define TLPWM_OFS_CH0_DUTY_LOW      8'h10
`define TLPWM_OFS_CH0_OUT_CONTROL   8'h14
`define TLPWM_OFS_CH1_DUTY_HIGH     8'h18
`define TLPWM_OFS_CH1_DUTY_LOW      8'h1C
`define TLPWM_OFS_CH1_OUT_CONTROL   8'h20
`define TLPWM_OFS_CH2_DUTY_HIGH     8'h24
`define TLPWM_OFS_CH2_DUTY_LOW      8'h28
`define TLPWM_OFS_CH2_OUT_CONTROL   8'h2C
`define TLPWM_OFS_COMP_GATE_SELECT  8'h30
`define TLPWM_OFS_COUNTER_STATUS    8'h34

// Clock control fields.
`define TLPWM_CLK_ENABLE_BIT        7
`define TLPWM_CLK_PRESCALE_MSB      6
`define TLPWM_CLK_PRESCALE_LSB      4
`define TLPWM_CLK_SOURCE_BIT        0

// Bound and duty low register fields.
`define TLPWM_LOW_BITS_MSB          7
`define TLPWM_LOW_BITS_LSB          6
`define TLPWM_HALF_STEP_BIT         5

// Channel output control fields.
`define TLPWM_OUT_INVERT_BIT        7
`define TLPWM_OUT_OR_BIT            5
`define TLPWM_OUT_XOR_BIT           4
`define TLPWM_OUT_PIN_SECOND_BIT    1
`define TLPWM_OUT_PIN_FIRST_BIT     0

// Reset value of every writable register.
`define TLPWM_REG_RESET             8'h00

// Bus answer latency in clock cycles from the first request cycle.
`define TLPWM_BUS_WAIT_CYCLES       1

`endif

//--- include/tlpwm_pkg.sv
// Types shared by the triple pwm generator modules.
package tlpwm_pkg;

  // Source of the shared counter clock.
  typedef enum logic [0:0]
  {
    TLPWM_SRC_SYSTEM = 1'b0,
    TLPWM_SRC_FAST   = 1'b1
  } tlpwm_src_t;

  // Channel zero combination with channel one.
  typedef enum logic [1:0]
  {
    TLPWM_MIX_NONE = 2'b00,
    TLPWM_MIX_XOR  = 2'b01,
    TLPWM_MIX_OR   = 2'b10,
    TLPWM_MIX_BOTH = 2'b11
  } tlpwm_mix_t;

  // Builds a 10-bit bound from a high byte and the two top bits of a low byte.
  function automatic logic [9:0] tlpwm_bits10(input logic [7:0] hi, input logic [7:0] lo);
    tlpwm_bits10 = {hi, lo[7:6]};
  endfunction

endpackage

//--- rtl/tlpwm_chan.sv
// One pwm channel comparator producing the raw waveform from the shared count.
`timescale 1ns/1ps
`include "tlpwm_regs.svh"

module tlpwm_chan
  import tlpwm_pkg::*;
#(
  parameter int W = 10
)
(
  // Clock and reset.
  input  wire logic         i_core_clk,
  input  wire logic         i_nrst,
  // Shared time base.
  input  wire logic [W-1:0] i_count,
  input  wire logic         i_first_half,
  // Duty registers.
  input  wire logic [7:0]   i_duty_high,
  input  wire logic [7:0]   i_duty_low,
  // Raw waveform.
  output logic              o_wave_q
);

  logic [W-1:0] duty_upper_bits;
  logic         duty_half_step_bit;
  logic         wave_d;

  // Duty bound decode; the half step stretches the last count by half a count.
  always_comb
  begin
    duty_upper_bits    = tlpwm_bits10(i_duty_high, i_duty_low);
    duty_half_step_bit = i_duty_low[`TLPWM_HALF_STEP_BIT];
    wave_d             = (i_count < duty_upper_bits) ||
                         ((i_count == duty_upper_bits) && (duty_half_step_bit || i_first_half));
  end

  // The waveform is registered so the pins never glitch on compare edges.
  always_ff @(posedge i_core_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      o_wave_q <= 1'b0;
    else
      o_wave_q <= wave_d;
  end

  AST_DUTY_HIGH: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (i_count < duty_upper_bits) |=> o_wave_q)
    else $error("Channel low while count below duty bound.");

  AST_DUTY_LOW: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (i_count > duty_upper_bits) |=> !o_wave_q)
    else $error("Channel high while count beyond duty bound.");

endmodule // tlpwm_chan

//--- test/tlpwm_far_side.sv
// Far side of the pwm block: oscillator, comparator and the pin loads.
`timescale 1ns/1ps

module tlpwm_far_side
(
  // Comparator level wanted by the bench.
  input  wire logic       i_cmp_level,
  // Pin data and active-low drive enables, a3 a4 a0 a7 from bit 0 up.
  input  wire logic [3:0] i_pin,
  input  wire logic [3:0] i_pin_en_n,
  // Sources feeding the block.
  output logic            o_fast_osc,
  output logic            o_comparator,
  // Levels seen at the loads.
  output logic [3:0]      o_pad
);
  // The oscillator runs free at 25 MHz; the 3 ns offset keeps it off the core edges.
  initial
  begin
    o_fast_osc = 1'b0;
    #3;
    forever #20 o_fast_osc = ~o_fast_osc;
  end

  // The comparator follows the level asked for, with no timing relation to the core clock.
  assign o_comparator = i_cmp_level;

  // Loads have pull-downs, so an undriven pin reads low rather than its last value.
  assign o_pad = ~i_pin_en_n & i_pin;
endmodule // tlpwm_far_side

//--- test/tb_top.sv
// Self-checking bench of the triple pwm generator driven over its register bus.
`timescale 1ns/1ps
`include "tlpwm_regs.svh"

module tb_top;
  // Bench signals.
  logic        clk;
  logic        nrst;
  logic [7:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        cmp_level;
  logic        fast_osc;
  logic        comparator;
  logic [3:0]  pin;
  logic [3:0]  pin_en_n;
  logic [3:0]  pad;
  int          miscompares;
  int          total_checks;
  int          cycles;
  int          hi;
  logic [31:0] rd;
  logic [7:0]  mix_cfg [6] = '{8'h01, 8'h81, 8'h11, 8'h91, 8'h21, 8'h31};
  int          mix_hi  [6] = '{3, 7, 4, 6, 7, 7};

  // Clock of 10 ns period.
  always #5 clk = ~clk;

  tlpwm_top i_dut
  (
    .i_core_clk        (clk),
    .i_nrst            (nrst),
    .i_avs_address     (avs_address),
    .i_avs_read        (avs_read),
    .i_avs_write       (avs_write),
    .i_avs_writedata   (avs_writedata),
    .o_avs_readdata    (avs_readdata),
    .o_avs_waitrequest (avs_waitrequest),
    .i_fast_osc        (fast_osc),
    .i_comparator      (comparator),
    .o_pin_a3          (pin[0]),
    .o_pin_a3_en_n     (pin_en_n[0]),
    .o_pin_a4          (pin[1]),
    .o_pin_a4_en_n     (pin_en_n[1]),
    .o_pin_a0          (pin[2]),
    .o_pin_a0_en_n     (pin_en_n[2]),
    .o_pin_a7          (pin[3]),
    .o_pin_a7_en_n     (pin_en_n[3])
  );

  tlpwm_far_side i_far
  (
    .i_cmp_level  (cmp_level),
    .i_pin        (pin),
    .i_pin_en_n   (pin_en_n),
    .o_fast_osc   (fast_osc),
    .o_comparator (comparator),
    .o_pad        (pad)
  );

  // Prints the counts and the verdict, then ends the run.
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // A hung wait must not stall the run, so a cycle ceiling ends it.
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 60000)
    begin
      miscompares = miscompares + 1;
      give_verdict();
    end
  end

  // Compares one value and reports a mismatch at once.
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  // One bus transfer; the request is held until waitrequest is sampled low, however long that takes.
  task automatic bus(input logic w, input logic [7:0] addr, input logic [7:0] data, output logic [31:0] q);
    int n;
    @(posedge clk);
    avs_address   <= addr;
    avs_writedata <= {24'h000000, data};
    avs_write     <= w;
    avs_read      <= ~w;
    for (n = 0; n == 0 || avs_waitrequest !== 1'b0; n++) @(posedge clk);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask

  // Waits, with a bound, until a pad shows the given level.
  task automatic wait_pad(input int k, input logic v);
    int n;
    for (n = 0; pad[k] !== v && n < 3000; n++) @(posedge clk);
  endtask

  // Measures one period from a rising edge and compares period and high time.
  // A setting change can raise the pad in mid-period, so the first rise seen is skipped.
  task automatic wave(input int k, input int exp_per, input int exp_hi);
    int h;
    int p;
    wait_pad(k, 1'b0);
    wait_pad(k, 1'b1);
    wait_pad(k, 1'b0);
    wait_pad(k, 1'b1);
    for (h = 0; pad[k] === 1'b1 && h < 3000; h++) @(posedge clk);
    for (p = h; pad[k] === 1'b0 && p < 6000; p++) @(posedge clk);
    check("period", 32'(exp_per), 32'(p));
    check("high time", 32'(exp_hi), 32'(h));
  endtask

  // Counts the cycles a pad is high within a window.
  task automatic count_high(input int k, input int n, output int h);
    h = 0;
    repeat (n)
    begin
      @(posedge clk);
      h += (pad[k] === 1'b1);
    end
  endtask

  // Main sequence.
  initial
  begin
    clk           = 1'b0;
    nrst          = 1'b0;
    avs_address   = 8'h00;
    avs_read      = 1'b0;
    avs_write     = 1'b0;
    avs_writedata = 32'h00000000;
    cmp_level     = 1'b0;
    miscompares   = 0;
    total_checks  = 0;
    cycles        = 0;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    for (int a = 0; a <= 8'h3C; a += 4)
    begin
      bus(1'b0, 8'(a), 8'h00, rd);
      check("reset read", 32'h00000000, rd);
    end
    check("pins released", 32'h0000000F, {28'h0000000, pin_en_n});
    bus(1'b1, 8'h3C, 8'hFF, rd);
    bus(1'b0, 8'h3C, 8'h00, rd);
    check("unmapped read", 32'h00000000, rd);
    bus(1'b1, `TLPWM_OFS_BOUND_HIGH, 8'h02, rd);
    bus(1'b0, `TLPWM_OFS_BOUND_HIGH, 8'h00, rd);
    check("bound high", 32'h00000002, rd);
    // Bound 9 gives ten counts; duties 2, 6 and 7, each with the half step set.
    bus(1'b1, `TLPWM_OFS_BOUND_LOW, 8'h40, rd);
    bus(1'b1, `TLPWM_OFS_CH0_DUTY_LOW, 8'hA0, rd);
    bus(1'b1, `TLPWM_OFS_CH1_DUTY_HIGH, 8'h01, rd);
    bus(1'b1, `TLPWM_OFS_CH1_DUTY_LOW, 8'hA0, rd);
    bus(1'b1, `TLPWM_OFS_CH2_DUTY_HIGH, 8'h01, rd);
    bus(1'b1, `TLPWM_OFS_CH2_DUTY_LOW, 8'hE0, rd);
    bus(1'b1, `TLPWM_OFS_CH0_OUT_CONTROL, 8'h01, rd);
    bus(1'b1, `TLPWM_OFS_CH1_OUT_CONTROL, 8'h01, rd);
    bus(1'b1, `TLPWM_OFS_CH2_OUT_CONTROL, 8'h03, rd);
    $display("test registers done");
    // Every prescale step scales both period and high time.
    for (int p = 0; p < 8; p++)
    begin
      bus(1'b1, `TLPWM_OFS_CLOCK_CONTROL, 8'h80 | 8'(p << 4), rd);
      wave(0, 10 << p, 3 << p);
    end
    bus(1'b1, `TLPWM_OFS_CLOCK_CONTROL, 8'h80, rd);
    wave(1, 10, 7);
    wave(2, 10, 8);
    wave(3, 10, 8);
    wait_pad(0, 1'b0);
    wait_pad(0, 1'b1);
    check("shared start", 32'h00000003, {30'h00000000, pad[1:0]});
    bus(1'b0, `TLPWM_OFS_COUNTER_STATUS, 8'h00, rd);
    check("count in range", 32'h00000001, {31'h00000000, rd[9:0] <= 10'h009});
    $display("test period and routing done");
    // Without the half step the count equal to the duty is high only for half a prescale window.
    bus(1'b1, `TLPWM_OFS_CH0_DUTY_LOW, 8'h80, rd);
    wave(0, 10, 2);
    bus(1'b1, `TLPWM_OFS_CLOCK_CONTROL, 8'h90, rd);
    wave(0, 20, 5);
    bus(1'b1, `TLPWM_OFS_CLOCK_CONTROL, 8'h80, rd);
    bus(1'b1, `TLPWM_OFS_CH0_DUTY_LOW, 8'hA0, rd);
    bus(1'b1, `TLPWM_OFS_CH2_OUT_CONTROL, 8'h83, rd);
    wave(2, 10, 2);
    bus(1'b1, `TLPWM_OFS_CH2_OUT_CONTROL, 8'h01, rd);
    bus(1'b1, `TLPWM_OFS_CH1_OUT_CONTROL, 8'h00, rd);
    repeat (4) @(posedge clk);
    check("a7 and a4 released", 32'h00000003, {30'h00000000, pin_en_n[3], pin_en_n[1]});
    $display("test half step and inversion done");
    // Each mode is set ahead of a fresh period measure, so no half-updated period is judged.
    for (int m = 0; m < 6; m++)
    begin
      bus(1'b1, `TLPWM_OFS_CH0_OUT_CONTROL, mix_cfg[m], rd);
      wave(0, 10, mix_hi[m]);
    end
    bus(1'b1, `TLPWM_OFS_CH0_OUT_CONTROL, 8'h01, rd);
    bus(1'b1, `TLPWM_OFS_CH1_OUT_CONTROL, 8'h01, rd);
    $display("test combination done");
    // Gating of channel one alone must leave channel zero running.
    bus(1'b1, `TLPWM_OFS_COMP_GATE_SELECT, 8'h02, rd);
    cmp_level <= 1'b1;
    repeat (8) @(posedge clk);
    wave(0, 10, 3);
    count_high(1, 30, hi);
    check("gated a4", 32'h00000000, 32'(hi));
    bus(1'b1, `TLPWM_OFS_COMP_GATE_SELECT, 8'h01, rd);
    repeat (8) @(posedge clk);
    count_high(0, 30, hi);
    check("gated a3", 32'h00000000, 32'(hi));
    cmp_level <= 1'b0;
    wave(0, 10, 3);
    $display("test gating done");
    // Fast source ticks once every four core cycles.
    bus(1'b1, `TLPWM_OFS_CLOCK_CONTROL, 8'h81, rd);
    wave(0, 40, 12);
    bus(1'b1, `TLPWM_OFS_CLOCK_CONTROL, 8'h00, rd);
    repeat (20) @(posedge clk);
    bus(1'b0, `TLPWM_OFS_COUNTER_STATUS, 8'h00, rd);
    check("stopped count", 32'h00000000, {22'h000000, rd[9:0]});
    $display("test clock source and stop done");
    give_verdict();
  end
endmodule // tb_top
